//--- rtl/afls_pkg.sv
// Shared constants and types of the axis fault and limit supervisor
package afls_pkg;
  // Clock and servo cycle timing
  localparam int CLK_NS = 20;
  localparam int SERVO_NS = 1000000;
  localparam int SERVO_CYC = SERVO_NS / CLK_NS;
  localparam int NAX_DEF = 4;
  localparam int AXW = 2;
  // Global register byte offsets
  localparam logic [11:0] A_FLT = 12'h000;
  localparam logic [11:0] A_CTRL = 12'h004;
  localparam logic [11:0] A_ISTS = 12'h008;
  localparam logic [11:0] A_IMSK = 12'h00c;
  // Axis block at 0x100 + axis * 0x40 + index * 4
  localparam logic [3:0] AX_REGION = 4'h1;
  localparam logic [3:0] R_MASK = 4'h0;
  localparam logic [3:0] R_TRIP = 4'h1;
  localparam logic [3:0] R_RNG = 4'h2;
  localparam logic [3:0] R_HOLD = 4'h3;
  localparam logic [3:0] R_FSB = 4'h4;
  localparam logic [3:0] R_JOG = 4'h5;
  localparam logic [3:0] R_SPD = 4'h6;
  localparam logic [3:0] R_SEL = 4'h7;
  localparam logic [3:0] R_BSEL = 4'h8;
  localparam logic [3:0] R_MOVE = 4'h9;
  localparam logic [3:0] R_COND = 4'ha;
  localparam logic [3:0] R_LAG = 4'hb;
  localparam logic [3:0] R_OUT = 4'hc;
  // Field positions
  localparam int CTL_CLR = 0;
  localparam int CTL_RELAY = 1;
  localparam int CTL_HALT = 2;
  localparam int MV_START = 0;
  localparam int MV_CANCEL = 1;
  localparam int MV_MODE = 2;
  localparam int C_RANGE = 1;
  localparam int C_FLIM = 4;
  localparam int C_HOLD = 7;
  localparam int C_TRIP = 8;
  localparam int C_SOFT = 9;
  localparam int I_FLT = 0;
  localparam int I_SOFT = 1;
  localparam int DEC_SHIFT = 4;
  // Reset values and input number ranges
  localparam logic [31:0] MASK_RST = 32'h0000_0100;
  localparam logic [31:0] HOLD_RST = 32'h0000_0000;
  localparam logic [7:0] SEL_NONE = 8'hff;
  localparam logic [7:0] SEL_LO_MAX = 8'h0f;
  localparam logic [7:0] SEL_HI_MIN = 8'h14;
  localparam logic [7:0] SEL_HI_MAX = 8'h1f;
  typedef enum logic [1:0] {MV_SPEED = 2'h0, MV_CAM = 2'h1, MV_CONN = 2'h2,
    MV_LINK = 2'h3} afls_mode_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_DEC = 2'b11} afls_st_t;
endpackage

//--- rtl/afls_axis.sv
// One axis: position lag, condition word, forward move and jog speed
module afls_axis
  import afls_pkg::*;
(
  // Clock, reset, servo tick
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  // Move commands
  input wire logic start_fwd,
  input wire logic cancel,
  input wire logic inhibit,
  input wire afls_mode_t mode,
  // Positions and settings
  input wire logic [31:0] cmd_pos,
  input wire logic [31:0] meas_pos,
  input wire logic [31:0] trip_lim,
  input wire logic [31:0] rep_rng,
  input wire logic [31:0] fs_bnd,
  input wire logic [31:0] move_spd,
  input wire logic [31:0] jog_rate,
  input wire logic [31:0] hold_rate,
  // Decoded machine inputs, high when asserted
  input wire logic hold_on,
  input wire logic fast_on,
  input wire logic flim_on,
  input wire logic fjog_on,
  input wire logic bjog_on,
  // Results
  output logic [31:0] cond_q,
  output logic [31:0] lag_q,
  output logic [31:0] speed_q,
  output logic rev_q,
  output logic bstop_q
);
  afls_st_t st_q, st_d;
  logic [31:0] lag_d, mag, step;
  logic [31:0] jspd;
  logic past_fs;

  // Lag is signed; limits compare against its magnitude
  assign lag_d = cmd_pos - meas_pos;
  assign mag = lag_d[31] ? (32'h0 - lag_d) : lag_d;
  assign past_fs = $signed(cmd_pos) >= $signed(fs_bnd);
  assign step = move_spd >> DEC_SHIFT;
  assign jspd = fast_on ? move_spd : jog_rate;

  // Lag and condition word refresh once per servo cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lag_q <= 32'h0;
      cond_q <= 32'h0;
    end
    else if (tick)
    begin
      lag_q <= lag_d;
      cond_q <= 32'h0;
      cond_q[C_RANGE] <= mag > rep_rng;
      cond_q[C_FLIM] <= flim_on;
      cond_q[C_HOLD] <= hold_on;
      cond_q[C_TRIP] <= mag > trip_lim;
      cond_q[C_SOFT] <= $signed(cmd_pos) > $signed(fs_bnd);
    end
  end

  // Forward move sequence; the hard limit and halts stop at once
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (start_fwd && !flim_on && !inhibit)
          st_d = ST_RUN;
      ST_RUN:
        if (cancel || inhibit || flim_on)
          st_d = ST_IDLE;
        else if (past_fs)
          st_d = ST_DEC;
      ST_DEC:
        if (cancel || flim_on || (tick && speed_q <= step))
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;
  end

  // Speed demand; hold slows only speed-controlled moves
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      speed_q <= 32'h0;
      rev_q <= 1'b0;
      bstop_q <= 1'b0;
    end
    else
    begin
      bstop_q <= st_q == ST_DEC && st_d == ST_IDLE && !cancel && !flim_on;
      if (tick)
      begin
        rev_q <= 1'b0;
        if (st_q == ST_RUN)
          speed_q <= (hold_on && mode == MV_SPEED) ? hold_rate : move_spd;
        else if (st_q == ST_DEC)
          speed_q <= (speed_q > step) ? speed_q - step : 32'h0;
        else if (fjog_on && !flim_on)
          speed_q <= jspd;
        else if (bjog_on)
        begin
          speed_q <= jspd;
          rev_q <= 1'b1;
        end
        else
          speed_q <= 32'h0;
      end
    end
  end

  a_trip_bit: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> cond_q[C_TRIP] == ($past(mag) > $past(trip_lim)))
    else $error("lag trip bit wrong");
  a_range_bit: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> cond_q[C_RANGE] == ($past(mag) > $past(rep_rng)))
    else $error("lag range bit wrong");
  a_lag_value: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> lag_q == $past(cmd_pos) - $past(meas_pos))
    else $error("lag value wrong");
  a_hold_speed: assert property (@(posedge pclk) disable iff (!presetn)
    tick && st_q == ST_RUN && hold_on && mode == MV_SPEED |=> speed_q == $past(hold_rate))
    else $error("hold speed not applied");
  a_flim_stop: assert property (@(posedge pclk) disable iff (!presetn)
    flim_on && st_q != ST_IDLE |=> st_q == ST_IDLE)
    else $error("forward limit did not stop");
  a_jog_fast: assert property (@(posedge pclk) disable iff (!presetn)
    tick && st_q == ST_IDLE && fjog_on && !flim_on |=> speed_q == $past(jspd))
    else $error("jog speed wrong");
endmodule

//--- rtl/afls_top.sv
// Axis fault and limit supervisor with APB register access
module afls_top
  import afls_pkg::*;
#(
  parameter int NAX = afls_pkg::NAX_DEF,
  parameter int SERVO_CYCLES = afls_pkg::SERVO_CYC
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Machine inputs and positions
  input wire logic [31:0] in_pins,
  input wire logic inhibit_pin,
  input wire logic [NAX*32-1:0] cmd_pos,
  input wire logic [NAX*32-1:0] meas_pos,
  // Drive side
  output logic drive_enable_relay,
  output logic motion_fault,
  output logic [AXW-1:0] fault_axis,
  output logic [NAX*32-1:0] axis_speed,
  output logic [NAX-1:0] axis_rev,
  output logic irq
);
  localparam int CW = $clog2(SERVO_CYCLES);

  logic [31:0] in_s1_q, in_s2_q;
  logic inh_s1_q, inh_s2_q;
  logic [CW-1:0] cyc_q;
  logic tick_q, tick_d1_q;
  logic [31:0] mask_q [NAX];
  logic [31:0] trip_q [NAX];
  logic [31:0] rng_q [NAX];
  logic [31:0] hold_q [NAX];
  logic [31:0] fsb_q [NAX];
  logic [31:0] jog_q [NAX];
  logic [31:0] spd_q [NAX];
  logic [31:0] sel_q [NAX];
  logic [7:0] bsel_q [NAX];
  afls_mode_t mode_q [NAX];
  logic [NAX-1:0] start_q, canc_q, hit, bstop;
  logic [31:0] cond_w [NAX];
  logic [31:0] lag_w [NAX];
  logic [31:0] spd_w [NAX];
  logic flt_q, relay_q, halt_q;
  logic [AXW-1:0] fax_q, first;
  logic [1:0] ists_q, imsk_q;
  logic pready_q, perr_q, irq_q;
  logic [31:0] prdata_q, rd_d;
  logic setup, acc, wr, ax_hit, err_d, new_flt, sel_bad;
  logic [AXW-1:0] ax;
  logic [3:0] ri;

  // Input number is accepted only in the two wired ranges, or none
  function automatic logic sel_ok(input logic [7:0] s);
    sel_ok = s == SEL_NONE || s <= SEL_LO_MAX || (s >= SEL_HI_MIN && s <= SEL_HI_MAX);
  endfunction

  // Inputs are wired fail-safe, so a low level means asserted
  function automatic logic sel_hit(input logic [7:0] s, input logic [31:0] v);
    sel_hit = s != SEL_NONE && sel_ok(s) && !v[s[4:0]];
  endfunction

  // Machine pins come from outside the clock domain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_s1_q <= 32'hffff_ffff;
      in_s2_q <= 32'hffff_ffff;
      inh_s1_q <= 1'b0;
      inh_s2_q <= 1'b0;
    end
    else
    begin
      in_s1_q <= in_pins;
      in_s2_q <= in_s1_q;
      inh_s1_q <= inhibit_pin;
      inh_s2_q <= inh_s1_q;
    end
  end

  // Servo cycle tick; fault check runs one cycle later on fresh conditions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_q <= '0;
      tick_q <= 1'b0;
      tick_d1_q <= 1'b0;
    end
    else
    begin
      tick_q <= cyc_q == CW'(SERVO_CYCLES - 1);
      cyc_q <= (cyc_q == CW'(SERVO_CYCLES - 1)) ? '0 : cyc_q + 1'b1;
      tick_d1_q <= tick_q;
    end
  end

  // APB decode
  assign setup = psel && !penable;
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite && !perr_q;
  assign ax_hit = paddr[11:8] == AX_REGION && int'(paddr[7:6]) < NAX;
  assign ax = paddr[7:6];
  assign ri = paddr[5:2];
  assign sel_bad = !sel_ok(pwdata[7:0]) || !sel_ok(pwdata[15:8])
    || !sel_ok(pwdata[23:16]) || !sel_ok(pwdata[31:24]);

  // Read mux and error decision, both made in the setup cycle
  always_comb
  begin
    rd_d = 32'h0;
    err_d = 1'b0;
    if (ax_hit)
    begin
      case (ri)
        R_MASK: rd_d = mask_q[ax];
        R_TRIP: rd_d = trip_q[ax];
        R_RNG: rd_d = rng_q[ax];
        R_HOLD: rd_d = hold_q[ax];
        R_FSB: rd_d = fsb_q[ax];
        R_JOG: rd_d = jog_q[ax];
        R_SPD: rd_d = spd_q[ax];
        R_SEL: rd_d = sel_q[ax];
        R_BSEL: rd_d = {24'h0, bsel_q[ax]};
        R_MOVE: rd_d = {28'h0, mode_q[ax], 2'b00};
        R_COND: rd_d = cond_w[ax];
        R_LAG: rd_d = lag_w[ax];
        R_OUT: rd_d = spd_w[ax];
        default: err_d = 1'b1;
      endcase
      // Out of range selects and negative hold rates are refused
      if (pwrite && ri == R_SEL && sel_bad)
        err_d = 1'b1;
      if (pwrite && ri == R_BSEL && !sel_ok(pwdata[7:0]))
        err_d = 1'b1;
      if (pwrite && ri == R_HOLD && pwdata[31])
        err_d = 1'b1;
    end
    else
    begin
      case (paddr)
        A_FLT: rd_d = {22'h0, {(8-AXW){1'b0}}, fax_q, 1'b0, flt_q};
        A_CTRL: rd_d = {29'h0, halt_q, relay_q, 1'b0};
        A_ISTS: rd_d = {30'h0, ists_q};
        A_IMSK: rd_d = {30'h0, imsk_q};
        default: err_d = 1'b1;
      endcase
    end
  end

  // One wait-free access phase: ready rises the cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      perr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= setup;
      perr_q <= setup && err_d;
      if (setup && !pwrite)
        prdata_q <= rd_d;
    end
  end

  // Per-axis settings written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NAX; i++)
      begin
        mask_q[i] <= MASK_RST;
        trip_q[i] <= 32'h0;
        rng_q[i] <= 32'h0;
        hold_q[i] <= HOLD_RST;
        fsb_q[i] <= 32'h7fff_ffff;
        jog_q[i] <= 32'h0;
        spd_q[i] <= 32'h0;
        sel_q[i] <= {4{SEL_NONE}};
        bsel_q[i] <= SEL_NONE;
        mode_q[i] <= MV_SPEED;
      end
      start_q <= '0;
      canc_q <= '0;
    end
    else
    begin
      start_q <= '0;
      canc_q <= '0;
      for (int i = 0; i < NAX; i++)
      begin
        if (wr && ax_hit && int'(ax) == i)
        begin
          case (ri)
            R_MASK: mask_q[i] <= pwdata;
            R_TRIP: trip_q[i] <= pwdata;
            R_RNG: rng_q[i] <= pwdata;
            R_HOLD: hold_q[i] <= pwdata;
            R_FSB: fsb_q[i] <= pwdata;
            R_JOG: jog_q[i] <= pwdata;
            R_SPD: spd_q[i] <= pwdata;
            R_SEL: sel_q[i] <= pwdata;
            R_BSEL: bsel_q[i] <= pwdata[7:0];
            R_MOVE:
            begin
              mode_q[i] <= afls_mode_t'(pwdata[MV_MODE+1:MV_MODE]);
              start_q[i] <= pwdata[MV_START];
              canc_q[i] <= pwdata[MV_CANCEL];
            end
            default: ;
          endcase
        end
      end
    end
  end

  // One evaluator per axis
  genvar g;
  generate
    for (g = 0; g < NAX; g++)
    begin : g_ax
      afls_axis u_axis (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_q),
        .start_fwd(start_q[g]),
        .cancel(canc_q[g] || halt_q),
        .inhibit(inh_s2_q),
        .mode(mode_q[g]),
        .cmd_pos(cmd_pos[g*32 +: 32]),
        .meas_pos(meas_pos[g*32 +: 32]),
        .trip_lim(trip_q[g]),
        .rep_rng(rng_q[g]),
        .fs_bnd(fsb_q[g]),
        .move_spd(spd_q[g]),
        .jog_rate(jog_q[g]),
        .hold_rate(hold_q[g]),
        .hold_on(sel_hit(sel_q[g][15:8], in_s2_q)),
        .fast_on(sel_hit(sel_q[g][7:0], in_s2_q)),
        .flim_on(sel_hit(sel_q[g][23:16], in_s2_q)),
        .fjog_on(sel_hit(sel_q[g][31:24], in_s2_q)),
        .bjog_on(sel_hit(bsel_q[g], in_s2_q)),
        .cond_q(cond_w[g]),
        .lag_q(lag_w[g]),
        .speed_q(spd_w[g]),
        .rev_q(axis_rev[g]),
        .bstop_q(bstop[g])
      );
      assign hit[g] = |(mask_q[g] & cond_w[g]);
      assign axis_speed[g*32 +: 32] = spd_w[g];
    end
  endgenerate

  // Lowest numbered axis wins when several fault in one cycle
  always_comb
  begin
    first = '0;
    for (int i = NAX - 1; i >= 0; i--)
      if (hit[i])
        first = AXW'(i);
  end

  assign new_flt = tick_d1_q && |hit && !flt_q;

  // Fault latch and relay; a new fault beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flt_q <= 1'b0;
      fax_q <= '0;
      relay_q <= 1'b0;
      halt_q <= 1'b0;
    end
    else
    begin
      halt_q <= wr && paddr == A_CTRL && pwdata[CTL_HALT];
      if (new_flt)
      begin
        flt_q <= 1'b1;
        fax_q <= first;
        relay_q <= 1'b0;
      end
      else if (wr && paddr == A_CTRL)
      begin
        if (pwdata[CTL_CLR])
          flt_q <= 1'b0;
        // Relay closes only by software and never over a held fault
        if (pwdata[CTL_RELAY] && !flt_q && !pwdata[CTL_CLR])
          relay_q <= 1'b1;
        else if (!pwdata[CTL_RELAY])
          relay_q <= 1'b0;
      end
    end
  end

  // Sticky events cleared by writing ones; the event wins a tie
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ists_q <= 2'b00;
      imsk_q <= 2'b00;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr && paddr == A_ISTS)
        ists_q <= ists_q & ~pwdata[1:0];
      if (new_flt)
        ists_q[I_FLT] <= 1'b1;
      if (|bstop)
        ists_q[I_SOFT] <= 1'b1;
      if (wr && paddr == A_IMSK)
        imsk_q <= pwdata[1:0];
      irq_q <= |(ists_q & imsk_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = perr_q;
  assign drive_enable_relay = relay_q;
  assign motion_fault = flt_q;
  assign fault_axis = fax_q;
  assign irq = irq_q;

  a_fault_trip: assert property (@(posedge pclk) disable iff (!presetn)
    tick_d1_q && |hit && !flt_q |=> !drive_enable_relay && motion_fault
      && fault_axis == $past(first))
    else $error("fault did not open relay");
  a_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
    flt_q && !(wr && paddr == A_CTRL) |=> flt_q && fault_axis == $past(fax_q))
    else $error("fault cleared without software");
  a_relay_open: assert property (@(posedge pclk) disable iff (!presetn)
    flt_q |-> !relay_q)
    else $error("relay closed during fault");
  a_mask_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> mask_q[0] == MASK_RST && hold_q[0] == HOLD_RST)
    else $error("mask reset wrong");
  a_jog_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> sel_q[0][31:24] == SEL_NONE)
    else $error("jog select reset wrong");
  a_sel_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && perr_q |=> $stable(sel_q[0]) && $stable(hold_q[0]))
    else $error("refused write stored");
endmodule

//--- sim/afls_partner.sv
// Model of encoders and machine input wiring
module afls_partner
(
  // From bench
  input wire logic [31:0] low_mask,
  input wire logic [127:0] cmd_set,
  input wire logic [127:0] lag_set,
  // To block
  output logic [31:0] in_pins,
  output logic [127:0] cmd_pos,
  output logic [127:0] meas_pos
);
  // Pulled-up inputs, so an open switch reads high
  assign in_pins = ~low_mask;
  assign cmd_pos = cmd_set;
  // Encoder trails the demand by the requested lag
  for (genvar i = 0; i < 4; i++)
  begin : g_ax
    assign meas_pos[32*i+:32] = cmd_set[32*i+:32] - lag_set[32*i+:32];
  end
endmodule

//--- sim/test_afls_top.sv
// Self-checking bench of the axis supervisor
module test_afls_top;
  import afls_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic relay, fault, irq, inhibit;
  logic [1:0] fault_axis;
  logic [3:0] axis_rev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, low_mask, in_pins;
  logic [127:0] cmd_set, lag_set, cmd_pos, meas_pos, axis_speed;
  int bad_count = 0;
  int n_tests = 0;

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Short servo period keeps the run brief
  afls_top #(.NAX(4), .SERVO_CYCLES(10)) DUT (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_pins(in_pins),
    .inhibit_pin(inhibit), .cmd_pos(cmd_pos), .meas_pos(meas_pos),
    .drive_enable_relay(relay), .motion_fault(fault), .fault_axis(fault_axis),
    .axis_speed(axis_speed), .axis_rev(axis_rev), .irq(irq));

  afls_partner u_far (.low_mask(low_mask), .cmd_set(cmd_set), .lag_set(lag_set),
    .in_pins(in_pins), .cmd_pos(cmd_pos), .meas_pos(meas_pos));

  // Compare and count
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      bad_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, s, x);
    end
  endtask

  // One APB transfer; request held until pready is seen high, the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function logic [11:0] ax(input logic [1:0] a, input logic [3:0] r);
    return {AX_REGION, a, r, 2'b00};
  endfunction

  // Several servo ticks, enough for any update chain
  task settle;
    repeat (40) @(posedge pclk);
  endtask

  task t_reset;
    apb(1'b0, ax(2'h0, R_MASK), 32'h0);
    chk(rv, MASK_RST);
    apb(1'b0, ax(2'h0, R_HOLD), 32'h0);
    chk(rv, HOLD_RST);
    apb(1'b0, ax(2'h0, R_SEL), 32'h0);
    chk(rv, {4{SEL_NONE}});
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk({31'h0, relay}, 32'h0);
    $display("t_reset done");
  endtask

  task t_sel;
    apb(1'b1, ax(2'h0, R_SEL), 32'h0306_0514);
    chk({31'h0, er}, 32'h0);
    apb(1'b1, ax(2'h0, R_SEL), 32'h0306_0510);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, ax(2'h0, R_SEL), 32'h0);
    chk(rv, 32'h0306_0514);
    apb(1'b1, ax(2'h0, R_HOLD), 32'h8000_0000);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, ax(2'h0, R_HOLD), 32'h0);
    chk({31'h0, er}, 32'h0);
    $display("t_sel done");
  endtask

  task t_jog;
    apb(1'b1, ax(2'h0, R_JOG), 32'h11);
    apb(1'b1, ax(2'h0, R_SPD), 32'h40);
    apb(1'b1, ax(2'h0, R_HOLD), 32'h5);
    low_mask <= 32'h8;
    settle;
    chk(axis_speed[31:0], 32'h11);
    low_mask <= 32'h0010_0008;
    settle;
    chk(axis_speed[31:0], 32'h40);
    apb(1'b1, ax(2'h0, R_BSEL), 32'h7);
    low_mask <= 32'h80;
    settle;
    chk(axis_speed[31:0], 32'h11);
    chk({31'h0, axis_rev[0]}, 32'h1);
    low_mask <= 32'h0;
    apb(1'b1, ax(2'h0, R_MOVE), 32'h1);
    settle;
    chk(axis_speed[31:0], 32'h40);
    low_mask <= 32'h20;
    settle;
    chk(axis_speed[31:0], 32'h5);
    apb(1'b0, ax(2'h0, R_COND), 32'h0);
    chk({31'h0, rv[C_HOLD]}, 32'h1);
    low_mask <= 32'h0;
    settle;
    chk(axis_speed[31:0], 32'h40);
    low_mask <= 32'h40;
    settle;
    chk(axis_speed[31:0], 32'h0);
    apb(1'b0, ax(2'h0, R_COND), 32'h0);
    chk({31'h0, rv[C_FLIM]}, 32'h1);
    low_mask <= 32'h0;
    apb(1'b1, ax(2'h0, R_MOVE), 32'h2);
    apb(1'b1, ax(2'h0, R_MOVE), 32'h5);
    low_mask <= 32'h20;
    settle;
    chk(axis_speed[31:0], 32'h40);
    apb(1'b1, ax(2'h0, R_MOVE), 32'h2);
    low_mask <= 32'h0;
    $display("t_jog done");
  endtask

  // Halt, inhibit and soft boundary each end a forward move on axis 2
  task t_stop;
    apb(1'b1, ax(2'h2, R_SPD), 32'h40);
    apb(1'b1, ax(2'h2, R_MOVE), 32'h1);
    settle;
    chk(axis_speed[95:64], 32'h40);
    apb(1'b1, A_CTRL, 32'h4);
    settle;
    chk(axis_speed[95:64], 32'h0);
    apb(1'b1, ax(2'h2, R_MOVE), 32'h1);
    settle;
    inhibit <= 1'b1;
    settle;
    chk(axis_speed[95:64], 32'h0);
    inhibit <= 1'b0;
    apb(1'b1, ax(2'h2, R_MOVE), 32'h1);
    settle;
    apb(1'b1, ax(2'h2, R_FSB), 32'h0);
    repeat (250) @(posedge pclk);
    chk(axis_speed[95:64], 32'h0);
    apb(1'b0, A_ISTS, 32'h0);
    chk(rv, 32'h2);
    apb(1'b1, A_ISTS, 32'h2);
    apb(1'b0, A_ISTS, 32'h0);
    chk(rv, 32'h0);
    $display("t_stop done");
  endtask

  // Fault mask stays at its lag-trip default all through
  task t_fault;
    cmd_set <= {4{32'h3e8}};
    apb(1'b1, ax(2'h1, R_TRIP), 32'h64);
    apb(1'b1, ax(2'h1, R_RNG), 32'h14);
    apb(1'b1, ax(2'h1, R_FSB), 32'h3e7);
    lag_set <= {64'h0, 32'h32, 32'h0};
    apb(1'b1, A_CTRL, 32'h2);
    settle;
    apb(1'b0, ax(2'h1, R_COND), 32'h0);
    chk(rv, 32'h202);
    apb(1'b0, ax(2'h1, R_LAG), 32'h0);
    chk(rv, 32'h32);
    chk({31'h0, relay}, 32'h1);
    lag_set <= {32'hc8, 32'h0, 32'hffff_ff6a, 32'h0};
    settle;
    apb(1'b0, ax(2'h1, R_COND), 32'h0);
    chk(rv, 32'h302);
    chk({relay, fault, irq, fault_axis}, {3'b010, 2'h1});
    lag_set <= 128'h0;
    apb(1'b1, A_CTRL, 32'h2);
    settle;
    chk({relay, fault}, 2'b01);
    apb(1'b1, A_IMSK, 32'h1);
    settle;
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_ISTS, 32'h1);
    apb(1'b1, A_CTRL, 32'h2);
    settle;
    chk({relay, fault, irq}, 3'b100);
    $display("t_fault done");
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog, far beyond the thousand or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    test_done;
  end

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    low_mask = 32'h0;
    inhibit = 1'b0;
    cmd_set = 128'h0;
    lag_set = 128'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset;
    t_sel;
    t_jog;
    t_stop;
    t_fault;
    test_done;
  end
endmodule
